// file: verilog/sc_pkg.sv
package sc_pkg;

  // Close timing selector codes
  typedef enum logic [1:0] {
    SC_TIMING_OFF,
    SC_TIMING_ASYNC,
    SC_TIMING_SYNC
  } sc_timing_t;

  // Stage-two pair selector codes
  localparam logic [1:0] SC_PAIR_MAIN_Y = 2'h0;
  localparam logic [1:0] SC_PAIR_MAIN_Z = 2'h1;
  localparam logic [1:0] SC_PAIR_Y_Z = 2'h2;

  // Voltage check code bits: dead-dead, dead-live, live-dead
  localparam int SC_VC_DD_BIT = 0;
  localparam int SC_VC_DL_BIT = 1;
  localparam int SC_VC_LD_BIT = 2;

  // Measurement units: magnitude 0.1 % of nominal, frequency mHz, angle 0.1 degree
  localparam logic [12:0] SC_FULL_TURN = 13'h0E10;
  localparam logic [12:0] SC_HALF_TURN = 13'h0708;
  localparam logic [12:0] SC_LL_SHIFT = 13'h012C;
  localparam logic [16:0] SC_FREQ_MIN = 17'h0B3B0;
  localparam logic [16:0] SC_FREQ_MAX = 17'h0FA00;
  localparam logic [9:0] SC_SQRT3_NUM = 10'h1BB;
  localparam int SC_SQRT3_SHIFT = 8;
  localparam logic [6:0] SC_HYST_NUM = 7'h61;
  localparam logic [6:0] SC_HYST_DEN = 7'h64;
  localparam logic [11:0] SC_SYNC_WINDOW = 12'h384;
  localparam int SC_ADV_SCALE = 36;
  localparam int SC_ADV_DIV = 10000;

  // Timing
  localparam int SC_CLK_MHZ = 200;
  localparam int SC_TICK_US = 1000;
  localparam int SC_TICK_CYCLES = SC_CLK_MHZ * SC_TICK_US;
  localparam int SC_FAIL_MS = 200;
  localparam logic [7:0] SC_FAIL_TICKS = 8'(SC_FAIL_MS * 1000 / SC_TICK_US);
  localparam int SC_TMO_MS_PER_UNIT = 100;

  // One measured side
  typedef struct packed {
    logic [11:0] mag;
    logic [16:0] freq;
    logic [11:0] phase;
  } sc_meas_t;

  // Settings
  typedef struct packed {
    sc_timing_t timing;
    logic [2:0] vcheck;
    logic [1:0] pair;
    logic [11:0] dead_lim;
    logic [11:0] live_lim;
    logic [9:0] slip_lim;
    logic [9:0] dv_lim;
    logic [9:0] angle_lim;
    logic [9:0] close_ms;
    logic [12:0] timeout;
  } sc_cfg_t;

endpackage : sc_pkg

// file: verilog/sc_side_conv.sv
`timescale 1ns/1ps
module sc_side_conv
  import sc_pkg::*;
(
  // Raw side measurement
  input wire sc_meas_t raw,
  input wire logic phase_neutral,
  // Line-to-line equivalent
  output sc_meas_t line
);

  logic [21:0] scaled;
  logic [12:0] shifted;

  // Phase-one-to-neutral becomes first-to-second line value: x sqrt3, +30 degrees
  always_comb begin
    scaled = 22'(raw.mag) * 22'(SC_SQRT3_NUM);
    shifted = 13'(raw.phase) + SC_LL_SHIFT;
    if (shifted >= SC_FULL_TURN) begin
      shifted = shifted - SC_FULL_TURN;
    end
    line.freq = raw.freq;
    if (phase_neutral) begin
      line.mag = (scaled[21:SC_SQRT3_SHIFT] > 14'h0FFF) ? 12'hFFF
               : scaled[SC_SQRT3_SHIFT +: 12]; // [RQ1] [RQ4]
      line.phase = shifted[11:0]; // [RQ4]
    end else begin
      line.mag = raw.mag;
      line.phase = raw.phase;
    end
  end

endmodule : sc_side_conv

// file: verilog/sc_sync_check.sv
`timescale 1ns/1ps
// Behaviour
// RQ1: Always check first-to-second line voltage, converting a phase-neutral main input.
// RQ2: Stage one always compares main side against y side.
// RQ3: Stage two compares main/y, main/z or y/z as selected.
// RQ4: Phase-neutral y and z inputs are converted to line-to-line values.
// RQ5: Timing selector off, async, sync; off drops frequency and phase criteria.
// RQ6: Async and sync apply slip, voltage and angle difference limits; sync checks a fixed 90 degree window, not angle_lim.
// RQ7: Async closes so contact lands inside the angle limit.
// RQ8: Sync closes so contact lands at zero phase difference; only a rising crossing (comparison side faster) is taken.
// RQ9: Close is advanced by slip frequency times breaker closing time.
// RQ10: Seven voltage check codes; first letter reference, second comparison side.
// RQ11: A side is dead only below the dead limit.
// RQ12: A side is live only strictly above the live limit.
// RQ13: Request output stands from close command until synchronism or timeout.
// RQ14: Timeout without synchronism gives a 200 ms fail pulse.
// RQ15: Frequency-phase synchronism needs both sides live and all differences met.
// RQ16: Bypass declares synchronism continuously while asserted.
// RQ17: No synchronism outside operating frequency range; thresholds have 0.97 hysteresis.
// RQ18: Combined voltage code passes if any constituent pairing passes.
module sc_sync_check
  import sc_pkg::*;
#(
  parameter bit STAGE_ONE = 1'b1,
  parameter int TICK_CYCLES = SC_TICK_CYCLES
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Measured sides
  input wire sc_meas_t main_side_line_voltage,
  input wire sc_meas_t y_side_line_voltage,
  input wire sc_meas_t z_side_line_voltage,
  input wire logic main_phase_neutral,
  input wire logic y_side_phase_neutral_input,
  input wire logic z_side_phase_neutral_input,
  // Settings and control
  input wire sc_cfg_t cfg,
  input wire logic close_request,
  input wire logic bypass,
  // Results
  output logic sync_ok,
  output logic sync_request,
  output logic sync_fail,
  output logic breaker_close
);

  typedef enum logic {
    SC_IDLE,
    SC_WAIT
  } sc_state_e;

  typedef struct packed {
    sc_state_e st;
    logic [17:0] tick_cnt;
    logic [19:0] tmo_cnt;
    logic [7:0] fail_cnt;
    logic live_r;
    logic dead_r;
    logic live_c;
    logic dead_c;
    logic pred_neg;
    logic ok;
    logic close;
  } sc_regs_t;

  sc_regs_t s_q;
  sc_regs_t s_d;
  sc_meas_t main_ll;
  sc_meas_t y_ll;
  sc_meas_t z_ll;
  sc_meas_t ref_m;
  sc_meas_t cmp_m;

  // Wrap a signed angle into one half turn either side of zero
  function automatic logic signed [13:0] sc_wrap(input logic signed [13:0] a);
    logic signed [13:0] r;
    r = a;
    if (r >= $signed({1'b0, SC_HALF_TURN})) begin
      r = r - $signed({1'b0, SC_FULL_TURN});
    end else if (r < -$signed({1'b0, SC_HALF_TURN})) begin
      r = r + $signed({1'b0, SC_FULL_TURN});
    end
    return r;
  endfunction : sc_wrap

  // Magnitude of a signed value
  function automatic logic [17:0] sc_abs(input logic signed [17:0] a);
    return (a < 0) ? 18'(-a) : 18'(a);
  endfunction : sc_abs

  // Live and dead flags with reset hysteresis
  function automatic logic sc_live(input logic was, input logic [11:0] v,
                                   input logic [11:0] lim);
    if (was) begin
      return 19'(v) * 19'(SC_HYST_DEN) > 19'(lim) * 19'(SC_HYST_NUM); // [RQ17]
    end
    return v > lim; // [RQ12]
  endfunction : sc_live

  function automatic logic sc_dead(input logic was, input logic [11:0] v,
                                   input logic [11:0] lim);
    if (was) begin
      return 19'(v) * 19'(SC_HYST_NUM) < 19'(lim) * 19'(SC_HYST_DEN); // [RQ17]
    end
    return v < lim; // [RQ11]
  endfunction : sc_dead

  function automatic logic sc_in_range(input logic [16:0] f);
    return (f >= SC_FREQ_MIN) && (f <= SC_FREQ_MAX);
  endfunction : sc_in_range

  // Line-to-line equivalents of each side
  sc_side_conv u_main (
    .raw(main_side_line_voltage),
    .phase_neutral(main_phase_neutral),
    .line(main_ll)
  ); // [RQ1]
  sc_side_conv u_y (
    .raw(y_side_line_voltage),
    .phase_neutral(y_side_phase_neutral_input),
    .line(y_ll)
  );
  sc_side_conv u_z (
    .raw(z_side_line_voltage),
    .phase_neutral(z_side_phase_neutral_input),
    .line(z_ll)
  );

  // Pair selection; stage one ignores the selector
  always_comb begin
    ref_m = main_ll;
    cmp_m = y_ll; // [RQ2]
    if (!STAGE_ONE) begin
      case (cfg.pair)
        SC_PAIR_MAIN_Z: cmp_m = z_ll; // [RQ3]
        SC_PAIR_Y_Z: begin
          ref_m = y_ll; // [RQ3]
          cmp_m = z_ll;
        end
        default: cmp_m = y_ll;
      endcase
    end
  end

  logic signed [17:0] slip;
  logic signed [13:0] pdiff;
  logic signed [31:0] adv_prod;
  logic signed [13:0] adv;
  logic signed [13:0] pred;
  logic [17:0] pred_abs;
  logic [17:0] dv_abs;
  logic v_ok;
  logic fp_ok;
  logic angle_ok;
  logic range_ok;
  logic now_ok;
  logic tick;

  // Difference criteria and close-instant prediction
  always_comb begin
    slip = 18'(signed'({1'b0, cmp_m.freq})) - 18'(signed'({1'b0, ref_m.freq}));
    pdiff = sc_wrap(14'(signed'({1'b0, cmp_m.phase})) - 14'(signed'({1'b0, ref_m.phase})));
    // Angle travelled during the breaker closing time, in 0.1 degree
    adv_prod = 32'(slip) * 32'(signed'({1'b0, cfg.close_ms})) * 32'(SC_ADV_SCALE);
    adv = 14'(adv_prod / SC_ADV_DIV); // [RQ9]
    pred = sc_wrap(pdiff + adv); // [RQ9]
    pred_abs = sc_abs(18'(pred));
    dv_abs = sc_abs(18'(signed'({1'b0, cmp_m.mag})) - 18'(signed'({1'b0, ref_m.mag})));
    // Voltage-only criterion, any constituent pairing suffices
    v_ok = (cfg.vcheck[SC_VC_DD_BIT] && s_q.dead_r && s_q.dead_c)
        || (cfg.vcheck[SC_VC_DL_BIT] && s_q.dead_r && s_q.live_c)
        || (cfg.vcheck[SC_VC_LD_BIT] && s_q.live_r && s_q.dead_c); // [RQ10] [RQ18]
    // Frequency of a live side must sit inside the operating range
    range_ok = (!s_q.live_r || sc_in_range(ref_m.freq))
            && (!s_q.live_c || sc_in_range(cmp_m.freq)); // [RQ17]
    // Sync aims at the zero crossing, async at entry into the angle window
    if (cfg.timing == SC_TIMING_SYNC) begin
      angle_ok = s_q.pred_neg && !pred[13] && (pred_abs < 18'(SC_SYNC_WINDOW)); // [RQ8]
    end else begin
      angle_ok = pred_abs <= 18'(cfg.angle_lim); // [RQ7]
    end
    fp_ok = (cfg.timing != SC_TIMING_OFF) && s_q.live_r && s_q.live_c
         && (sc_abs(slip) <= 18'(cfg.slip_lim))
         && (dv_abs <= 18'(cfg.dv_lim)) && angle_ok; // [RQ5] [RQ6] [RQ15]
    now_ok = bypass || (range_ok && (v_ok || fp_ok)); // [RQ16]
    tick = (s_q.tick_cnt == 18'(TICK_CYCLES - 1));
  end

  // Next state
  always_comb begin
    s_d = s_q;
    s_d.close = 1'b0;
    s_d.tick_cnt = tick ? 18'h00000 : s_q.tick_cnt + 18'h00001;
    s_d.live_r = sc_live(s_q.live_r, ref_m.mag, cfg.live_lim);
    s_d.live_c = sc_live(s_q.live_c, cmp_m.mag, cfg.live_lim);
    s_d.dead_r = sc_dead(s_q.dead_r, ref_m.mag, cfg.dead_lim);
    s_d.dead_c = sc_dead(s_q.dead_c, cmp_m.mag, cfg.dead_lim);
    s_d.pred_neg = pred[13];
    s_d.ok = now_ok;
    // Fail pulse length counted in millisecond ticks
    if (tick && s_q.fail_cnt != 8'h00) begin
      s_d.fail_cnt = s_q.fail_cnt - 8'h01; // [RQ14]
    end
    case (s_q.st)
      SC_IDLE: begin
        if (close_request) begin
          s_d.st = SC_WAIT; // [RQ13]
          s_d.tmo_cnt = 20'h00000;
        end
      end
      SC_WAIT: begin
        if (s_q.ok) begin
          s_d.close = 1'b1; // [RQ13]
          s_d.st = SC_IDLE;
        end else if (s_q.tmo_cnt >= 20'(cfg.timeout) * 20'(SC_TMO_MS_PER_UNIT)) begin
          s_d.fail_cnt = SC_FAIL_TICKS; // [RQ14]
          s_d.st = SC_IDLE;
        end else if (tick) begin
          s_d.tmo_cnt = s_q.tmo_cnt + 20'h00001;
        end
      end
      default: s_d.st = SC_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from state
  assign sync_ok = s_q.ok;
  assign sync_request = (s_q.st == SC_WAIT); // [RQ13]
  assign sync_fail = (s_q.fail_cnt != 8'h00); // [RQ14]
  assign breaker_close = s_q.close;

endmodule : sc_sync_check

// file: sim/sc_sync_check_asserts.sv
`timescale 1ns/1ps
module sc_sync_check_asserts
  import sc_pkg::*;
#(
  parameter int TICK_CYCLES = SC_TICK_CYCLES
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Inputs
  input wire sc_meas_t main_side_line_voltage,
  input wire sc_meas_t y_side_line_voltage,
  input wire logic main_phase_neutral,
  input wire logic y_side_phase_neutral_input,
  input wire sc_cfg_t cfg,
  input wire logic close_request,
  input wire logic bypass,
  // Results
  input wire logic sync_ok,
  input wire logic sync_request,
  input wire logic sync_fail,
  input wire logic breaker_close
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  localparam int F_LO = 199 * TICK_CYCLES;
  localparam int F_HI = 201 * TICK_CYCLES;
  logic both_dead;
  int fail_len_q;
  // Kept under 0.97 of the limit so hysteresis cannot leave a side undecided
  assign both_dead = !main_phase_neutral && !y_side_phase_neutral_input
    && main_side_line_voltage.mag * 100 < cfg.dead_lim * 97
    && y_side_line_voltage.mag * 100 < cfg.dead_lim * 97;
  // Fail pulse length in cycles
  always_ff @(posedge ref_clk) begin
    fail_len_q <= (srst || !sync_fail) ? 0 : fail_len_q + 1;
  end
  chk_req_start: assert property (close_request && !sync_request |=> sync_request)
    else $error("close request not taken");
  chk_close_cause: assert property (
    breaker_close |-> $past(sync_ok) && $past(sync_request)) else $error("close without sync");
  chk_close_once: assert property (breaker_close |-> !sync_request ##1 !breaker_close)
    else $error("close pulse malformed");
  chk_req_end: assert property (
    $fell(sync_request) && !$past(srst) |-> breaker_close || sync_fail) else $error("request cut");
  chk_fail_len: assert property (
    $fell(sync_fail) && !$past(srst) |-> fail_len_q >= F_LO && fail_len_q <= F_HI)
    else $error("fail pulse length");
  chk_bypass_ok: assert property (bypass [*3] |-> sync_ok)
    else $error("bypass not honoured");
  chk_range_block: assert property (
    (!bypass && cfg.vcheck == 3'h0 && y_side_line_voltage.freq > SC_FREQ_MAX) [*3] |-> !sync_ok)
    else $error("sync outside frequency range");
  chk_dead_pair: assert property (
    (!bypass && cfg.vcheck[SC_VC_DD_BIT] && both_dead) [*3] |-> sync_ok)
    else $error("dead pair refused");
  cov_close: cover property (breaker_close);
  cov_fail: cover property ($rose(sync_fail));
  cov_bypass: cover property (bypass && sync_ok);
endmodule : sc_sync_check_asserts

bind sc_sync_check sc_sync_check_asserts #(.TICK_CYCLES(TICK_CYCLES)) i_chk (
  .ref_clk, .srst, .main_side_line_voltage, .y_side_line_voltage, .main_phase_neutral,
  .y_side_phase_neutral_input, .cfg, .close_request, .bypass, .sync_ok, .sync_request,
  .sync_fail, .breaker_close
);

// file: sim/sc_meas_model.sv
`timescale 1ns/1ps
module sc_meas_model
  import sc_pkg::*;
(
  // Stimulus
  input wire logic ref_clk,
  input wire logic [1:0] live,
  input wire logic [16:0] y_freq,
  input wire logic [7:0] jit,
  // Measured sides
  output sc_meas_t main_v,
  output sc_meas_t y_v
);
  logic [11:0] ph_q = 12'h000;
  // Slip turns y once per 3600 cycles, far faster than real time
  always @(posedge ref_clk) begin
    ph_q <= (y_freq == 17'h0C350 || ph_q == 12'hE0F) ? 12'h000 : ph_q + 12'h001;
  end
  // Dead sides sit under 20 %, live ones over 90 %
  assign main_v = '{mag: (live[1] ? 12'h384 : 12'h032) + 12'(jit), freq: 17'h0C350, phase: 12'h000};
  assign y_v = '{mag: (live[0] ? 12'h384 : 12'h032) + 12'(jit), freq: y_freq, phase: ph_q};
endmodule : sc_meas_model

// file: sim/sc_sync_check_bench.sv
`timescale 1ns/1ps
module sc_sync_check_bench;
  import sc_pkg::*;
  // Stimulus and observed results
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic close_request = 1'b0;
  logic bypass = 1'b0;
  logic [1:0] live = 2'h0;
  logic [16:0] y_freq = 17'h0C350;
  logic [7:0] jit = 8'h00;
  logic fail_q = 1'b0;
  logic main_pn = 1'b0;
  logic y_pn = 1'b0;
  logic pair_ok;
  sc_cfg_t cfg;
  sc_meas_t main_v, y_v;
  logic sync_ok, sync_request, sync_fail, breaker_close;
  int err_count = 0;
  int samples_checked = 0;
  int seed = 48;
  logic exp_q[$];

  always #2.5 ref_clk = ~ref_clk;

  sc_meas_model i_meas (.ref_clk, .live, .y_freq, .jit, .main_v, .y_v);

  // Short tick keeps the timeout near 1000 cycles per 0.1 s unit
  // Z carries the main side, so a stage that picks the wrong pair is caught
  sc_sync_check #(.TICK_CYCLES(10)) i_dut (
    .ref_clk, .srst, .main_side_line_voltage(main_v), .y_side_line_voltage(y_v),
    .z_side_line_voltage(main_v), .main_phase_neutral(main_pn),
    .y_side_phase_neutral_input(y_pn), .z_side_phase_neutral_input(1'b0), .cfg,
    .close_request, .bypass, .sync_ok, .sync_request, .sync_fail, .breaker_close
  );

  // Stage two on the y/z pair, watched through its synchronism output only
  sc_sync_check #(.STAGE_ONE(1'b0), .TICK_CYCLES(10)) i_dut_pair (
    .ref_clk, .srst, .main_side_line_voltage(main_v), .y_side_line_voltage(y_v),
    .z_side_line_voltage(main_v), .main_phase_neutral(main_pn),
    .y_side_phase_neutral_input(y_pn), .z_side_phase_neutral_input(1'b0), .cfg,
    .close_request(1'b0), .bypass, .sync_ok(pair_ok), .sync_request(), .sync_fail(),
    .breaker_close()
  );

  task automatic flag(input string msg);
    err_count++;
    $display("CHECK FAILED %0t %s", $time, msg);
  endtask : flag

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick

  // One close attempt; ex high when a close is due, low when a fail is
  task automatic run_case(input logic [1:0] s, input logic ex);
    int n;
    n = 0;
    live = s;
    jit = 8'($random(seed)) & 8'h7F;
    tick(4);
    exp_q.push_back(ex);
    close_request = 1'b1;
    tick(1);
    close_request = 1'b0;
    samples_checked++;
    if (sync_request !== 1'b1) begin
      flag("request output not raised");
    end
    // Also waits out the fail pulse so the next onset is seen as a rise
    while ((sync_request !== 1'b0 || sync_fail !== 1'b0) && n < 9000) begin
      tick(1);
      n++;
    end
    if (n == 9000) begin
      flag("no answer to close request");
    end
  endtask : run_case

  task automatic conclude();
    if (err_count == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : conclude

  // Each close pulse or fail onset takes the oldest expectation
  always @(posedge ref_clk) begin
    fail_q <= sync_fail;
    if (breaker_close === 1'b1 || (sync_fail === 1'b1 && fail_q === 1'b0)) begin
      samples_checked++;
      if (exp_q.size() == 0) begin
        flag("outcome without request");
      end else if (exp_q.pop_front() !== breaker_close) begin
        flag("wrong close or fail outcome");
      end
    end
  end

  initial begin
    cfg = '{timing: SC_TIMING_OFF, vcheck: 3'h0, pair: SC_PAIR_Y_Z, dead_lim: 12'h12C,
      live_lim: 12'h320, slip_lim: 10'h064, dv_lim: 10'h064, angle_lim: 10'h0C8,
      close_ms: 10'h064, timeout: 13'h0001};
    tick(16);
    srst = 1'b0;
    tick(1);
    // Voltage-only closing: every check code against every side state
    for (int c = 1; c < 8; c++) begin
      cfg.vcheck = 3'(c);
      for (int s = 0; s < 4; s++) begin
        run_case(2'(s), s < 3 ? cfg.vcheck[s] : 1'b0);
      end
    end
    // Stage one keeps main/y while stage two follows the y/z pair
    cfg.vcheck = 3'h2;
    live = 2'h2;
    tick(4);
    samples_checked++;
    if (sync_ok !== 1'b0 || pair_ok !== 1'b1) begin
      flag("stage pair selection wrong");
    end
    // Phase-neutral inputs only clear the raised live limit once scaled to line values
    cfg.live_lim = 12'h41A;
    cfg.vcheck = 3'h4;
    main_pn = 1'b1;
    run_case(2'h2, 1'b1);
    main_pn = 1'b0;
    y_pn = 1'b1;
    cfg.vcheck = 3'h2;
    run_case(2'h1, 1'b1);
    y_pn = 1'b0;
    cfg.live_lim = 12'h320;
    cfg.vcheck = 3'h0;
    cfg.timeout = 13'h0005;
    bypass = 1'b1;
    run_case(2'h0, 1'b1);
    bypass = 1'b0;
    cfg.timing = SC_TIMING_ASYNC;
    run_case(2'h3, 1'b1);
    // Slip of 50 mHz: close lands on a zero crossing
    y_freq = 17'h0C382;
    cfg.timing = SC_TIMING_SYNC;
    run_case(2'h3, 1'b1);
    y_freq = 17'h11170;
    run_case(2'h3, 1'b0);
    // Voltage code alone is met, but the live side runs outside the operating range
    cfg.vcheck = 3'h2;
    cfg.timeout = 13'h0001;
    run_case(2'h1, 1'b0);
    conclude();
  end

  // Hang guard, well above the roughly 62000 cycles the run needs
  initial begin
    repeat (100000) @(posedge ref_clk);
    flag("watchdog expired");
    conclude();
  end
endmodule : sc_sync_check_bench
